// *** core/jid_pkg.sv ***
// Package for the test-port instruction decoder: codes, states, carrier types
package jid_pkg;
  localparam int IR_WIDTH = 8;
  localparam int ID_WIDTH = 32;
  localparam logic [31:0] ID_VALUE = 32'h0000_0001;
  localparam logic [7:0] INS_EXTEST = 8'h00;
  localparam logic [7:0] INS_IDCODE = 8'h21;
  localparam logic [7:0] INS_SAMPLE = 8'h05;
  localparam logic [7:0] INS_CLAMP = 8'h07;
  localparam logic [7:0] INS_HIGHZ = 8'h03;
  localparam logic [7:0] INS_BYPASS = 8'hFF;
  localparam logic [7:0] IR_CAPTURE_VAL = 8'h01;
  localparam logic [1:0] SYNC_RESET = 2'b00;
  localparam logic [3:0] ST_RESET = 4'h0;
  localparam logic [3:0] ST_IDLE = 4'h1;
  localparam logic [3:0] ST_SEL_DR = 4'h3;
  localparam logic [3:0] ST_CAP_DR = 4'h2;
  localparam logic [3:0] ST_SH_DR = 4'h6;
  localparam logic [3:0] ST_EX1_DR = 4'h7;
  localparam logic [3:0] ST_PAU_DR = 4'h5;
  localparam logic [3:0] ST_EX2_DR = 4'h4;
  localparam logic [3:0] ST_UPD_DR = 4'hC;
  localparam logic [3:0] ST_SEL_IR = 4'hD;
  localparam logic [3:0] ST_CAP_IR = 4'hF;
  localparam logic [3:0] ST_SH_IR = 4'hE;
  localparam logic [3:0] ST_EX1_IR = 4'hA;
  localparam logic [3:0] ST_PAU_IR = 4'hB;
  localparam logic [3:0] ST_EX2_IR = 4'h9;
  localparam logic [3:0] ST_UPD_IR = 4'h8;
  typedef enum logic [3:0] {
    S_RESET = ST_RESET, S_IDLE = ST_IDLE, S_SEL_DR = ST_SEL_DR, S_CAP_DR = ST_CAP_DR,
    S_SH_DR = ST_SH_DR, S_EX1_DR = ST_EX1_DR, S_PAU_DR = ST_PAU_DR, S_EX2_DR = ST_EX2_DR,
    S_UPD_DR = ST_UPD_DR, S_SEL_IR = ST_SEL_IR, S_CAP_IR = ST_CAP_IR, S_SH_IR = ST_SH_IR,
    S_EX1_IR = ST_EX1_IR, S_PAU_IR = ST_PAU_IR, S_EX2_IR = ST_EX2_IR, S_UPD_IR = ST_UPD_IR
  } jid_state_type;
  typedef enum logic [1:0] {
    PATH_BYPASS = 2'h0, PATH_BSR = 2'h1, PATH_ID = 2'h2
  } jid_path_type;
  // Decoded instruction as one bundle
  typedef struct packed {
    jid_path_type path;
    logic pins_from_bsr;
    logic pins_highz;
    logic capture_pins;
  } jid_decode_type;
  // Test port pins after synchronisation
  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
    logic trst_n;
  } jid_tap_type;
endpackage : jid_pkg

// *** core/jid_sync.sv ***
// Two-flop synchroniser for the test port pins
`timescale 1ns/10ps
module jid_sync #(
  parameter int WIDTH = 4
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;
  logic [WIDTH-1:0] nxt_meta;
  logic [WIDTH-1:0] nxt_sync;

  always_comb begin
    nxt_meta = clk_en ? async_in : meta_ff;
    nxt_sync = clk_en ? meta_ff : sync_ff;
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= nxt_meta;
      sync_ff <= nxt_sync;
    end
  end

  assign sync_out = sync_ff;
endmodule : jid_sync

// *** core/jid_decode.sv ***
// Test access port with instruction decoder for a memory device
// ---------------------------------------------------------------
// Summary of operation
// - Code 0000 0101 captures the memory input and read-data pin levels into the boundary register at capture-DR.
// - Under sample/preload the boundary register is the serial path in shift-DR.
// - Code 0000 0111 drives output balls from the boundary register and selects the bypass bit.
// - Code 0000 0011 forces all memory outputs to high impedance and selects the bypass bit.
// - Code 1111 1111 places the single bypass bit between test data in and out in shift-DR.
// - The eight-bit instruction shifts in shift-IR and takes effect only at update-IR.
// - Code 0000 0000 drives output pins from the boundary register and captures inputs as results.
// - Code 0010 0001 captures and shifts the identification value and is the reset default.
// ---------------------------------------------------------------
`timescale 1ns/10ps
module jid_decode #(
  parameter int IN_PINS = 8,
  parameter int OUT_PINS = 8,
  parameter logic [31:0] ID_CODE = jid_pkg::ID_VALUE // Arbitrary value
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  input wire logic trst_n,
  output logic tdo,
  output logic tdo_oe,
  input wire logic [IN_PINS-1:0] mem_in_pins,
  input wire logic [OUT_PINS-1:0] mem_func_out,
  input wire logic [OUT_PINS-1:0] mem_func_oe,
  output logic [OUT_PINS-1:0] pin_out,
  output logic [OUT_PINS-1:0] pin_oe,
  output logic [7:0] active_ir
);
  localparam int BSR_LEN = IN_PINS + 2 * OUT_PINS;
  localparam int IRW = jid_pkg::IR_WIDTH;
  localparam int IDW = jid_pkg::ID_WIDTH;

  // ---------------------------------------------------------------
  // Pin synchronisation and TCK edge detection
  // ---------------------------------------------------------------
  jid_pkg::jid_tap_type tap_s;
  logic tck_d_ff;
  logic nxt_tck_d;
  logic rise;
  logic fall;

  jid_sync #(.WIDTH(4)) u_sync (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .clk_en(clk_en),
    .async_in({tck, tms, tdi, trst_n}),
    .sync_out(tap_s)
  );

  always_comb begin
    nxt_tck_d = clk_en ? tap_s.tck : tck_d_ff;
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      tck_d_ff <= 1'b0;
    end else begin
      tck_d_ff <= nxt_tck_d;
    end
  end

  assign rise = clk_en & tap_s.tck & ~tck_d_ff;
  assign fall = clk_en & ~tap_s.tck & tck_d_ff;

  // ---------------------------------------------------------------
  // TAP state machine
  // ---------------------------------------------------------------
  jid_pkg::jid_state_type st_ff;
  jid_pkg::jid_state_type nxt_st;

  always_comb begin
    nxt_st = st_ff;
    if (clk_en && !tap_s.trst_n) begin
      nxt_st = jid_pkg::S_RESET;
    end else if (rise) begin
      case (st_ff)
        jid_pkg::S_RESET: nxt_st = tap_s.tms ? jid_pkg::S_RESET : jid_pkg::S_IDLE;
        jid_pkg::S_IDLE: nxt_st = tap_s.tms ? jid_pkg::S_SEL_DR : jid_pkg::S_IDLE;
        jid_pkg::S_SEL_DR: nxt_st = tap_s.tms ? jid_pkg::S_SEL_IR : jid_pkg::S_CAP_DR;
        jid_pkg::S_CAP_DR: nxt_st = tap_s.tms ? jid_pkg::S_EX1_DR : jid_pkg::S_SH_DR;
        jid_pkg::S_SH_DR: nxt_st = tap_s.tms ? jid_pkg::S_EX1_DR : jid_pkg::S_SH_DR;
        jid_pkg::S_EX1_DR: nxt_st = tap_s.tms ? jid_pkg::S_UPD_DR : jid_pkg::S_PAU_DR;
        jid_pkg::S_PAU_DR: nxt_st = tap_s.tms ? jid_pkg::S_EX2_DR : jid_pkg::S_PAU_DR;
        jid_pkg::S_EX2_DR: nxt_st = tap_s.tms ? jid_pkg::S_UPD_DR : jid_pkg::S_SH_DR;
        jid_pkg::S_UPD_DR: nxt_st = tap_s.tms ? jid_pkg::S_SEL_DR : jid_pkg::S_IDLE;
        jid_pkg::S_SEL_IR: nxt_st = tap_s.tms ? jid_pkg::S_RESET : jid_pkg::S_CAP_IR;
        jid_pkg::S_CAP_IR: nxt_st = tap_s.tms ? jid_pkg::S_EX1_IR : jid_pkg::S_SH_IR;
        jid_pkg::S_SH_IR: nxt_st = tap_s.tms ? jid_pkg::S_EX1_IR : jid_pkg::S_SH_IR;
        jid_pkg::S_EX1_IR: nxt_st = tap_s.tms ? jid_pkg::S_UPD_IR : jid_pkg::S_PAU_IR;
        jid_pkg::S_PAU_IR: nxt_st = tap_s.tms ? jid_pkg::S_EX2_IR : jid_pkg::S_PAU_IR;
        jid_pkg::S_EX2_IR: nxt_st = tap_s.tms ? jid_pkg::S_UPD_IR : jid_pkg::S_SH_IR;
        jid_pkg::S_UPD_IR: nxt_st = tap_s.tms ? jid_pkg::S_SEL_DR : jid_pkg::S_IDLE;
        default: nxt_st = jid_pkg::S_RESET;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      st_ff <= jid_pkg::S_RESET;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ---------------------------------------------------------------
  // Instruction decode
  // ---------------------------------------------------------------
  logic [IRW-1:0] ir_ff;
  jid_pkg::jid_decode_type dec;

  always_comb begin
    dec = '{path: jid_pkg::PATH_BYPASS, pins_from_bsr: 1'b0, pins_highz: 1'b0, capture_pins: 1'b0};
    case (ir_ff)
      jid_pkg::INS_EXTEST: begin
        dec.path = jid_pkg::PATH_BSR;
        dec.pins_from_bsr = 1'b1;
        dec.capture_pins = 1'b1;
      end
      jid_pkg::INS_SAMPLE: begin
        dec.path = jid_pkg::PATH_BSR;
        dec.capture_pins = 1'b1;
      end
      jid_pkg::INS_CLAMP: begin
        dec.pins_from_bsr = 1'b1;
      end
      jid_pkg::INS_HIGHZ: begin
        dec.pins_highz = 1'b1;
      end
      jid_pkg::INS_IDCODE: begin
        dec.path = jid_pkg::PATH_ID;
      end
      jid_pkg::INS_BYPASS: begin
        dec.path = jid_pkg::PATH_BYPASS;
      end
      default: begin
        dec.path = jid_pkg::PATH_BYPASS;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // Shift registers and update stages
  // ---------------------------------------------------------------
  logic [IRW-1:0] irs_ff, nxt_irs, nxt_ir;
  logic [IDW-1:0] ids_ff, nxt_ids;
  logic [BSR_LEN-1:0] bsr_ff, nxt_bsr, bupd_ff, nxt_bupd;
  logic byp_ff, nxt_byp;
  logic tdo_ff, nxt_tdo, tdo_oe_ff, nxt_tdo_oe;
  logic sel_bit;

  always_comb begin
    nxt_irs = irs_ff;
    nxt_ir = ir_ff;
    nxt_ids = ids_ff;
    nxt_bsr = bsr_ff;
    nxt_bupd = bupd_ff;
    nxt_byp = byp_ff;
    if (st_ff == jid_pkg::S_RESET) begin
      nxt_ir = jid_pkg::INS_IDCODE;
    end
    if (rise) begin
      case (st_ff)
        jid_pkg::S_CAP_IR: nxt_irs = jid_pkg::IR_CAPTURE_VAL;
        jid_pkg::S_SH_IR: nxt_irs = {tap_s.tdi, irs_ff[IRW-1:1]};
        jid_pkg::S_CAP_DR: begin
          nxt_byp = 1'b0;
          nxt_ids = ID_CODE;
          // Pins are sampled without clock alignment; the controller must hold them steady
          if (dec.capture_pins) begin
            nxt_bsr = {mem_func_oe, mem_func_out, mem_in_pins};
          end
        end
        jid_pkg::S_SH_DR: begin
          nxt_byp = tap_s.tdi;
          nxt_ids = {tap_s.tdi, ids_ff[IDW-1:1]};
          if (dec.path == jid_pkg::PATH_BSR) begin
            nxt_bsr = {tap_s.tdi, bsr_ff[BSR_LEN-1:1]};
          end
        end
        default: begin
        end
      endcase
    end
    if (fall && st_ff == jid_pkg::S_UPD_IR) begin
      nxt_ir = irs_ff;
    end
    if (fall && st_ff == jid_pkg::S_UPD_DR && dec.path == jid_pkg::PATH_BSR) begin
      nxt_bupd = bsr_ff;
    end
  end

  always_comb begin
    case (dec.path)
      jid_pkg::PATH_BSR: sel_bit = bsr_ff[0];
      jid_pkg::PATH_ID: sel_bit = ids_ff[0];
      default: sel_bit = byp_ff;
    endcase
  end

  // TDO changes on the falling TCK edge, as the far side samples on the rising one
  always_comb begin
    nxt_tdo = tdo_ff;
    nxt_tdo_oe = tdo_oe_ff;
    if (fall) begin
      nxt_tdo_oe = (st_ff == jid_pkg::S_SH_DR) || (st_ff == jid_pkg::S_SH_IR);
      nxt_tdo = (st_ff == jid_pkg::S_SH_IR) ? irs_ff[0] : sel_bit;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      irs_ff <= '0;
      ir_ff <= jid_pkg::INS_IDCODE;
      ids_ff <= '0;
      bsr_ff <= '0;
      bupd_ff <= '0;
      byp_ff <= 1'b0;
      tdo_ff <= 1'b0;
      tdo_oe_ff <= 1'b0;
    end else begin
      irs_ff <= nxt_irs;
      ir_ff <= nxt_ir;
      ids_ff <= nxt_ids;
      bsr_ff <= nxt_bsr;
      bupd_ff <= nxt_bupd;
      byp_ff <= nxt_byp;
      tdo_ff <= nxt_tdo;
      tdo_oe_ff <= nxt_tdo_oe;
    end
  end

  // ---------------------------------------------------------------
  // Output ball control
  // ---------------------------------------------------------------
  always_comb begin
    if (dec.pins_highz) begin
      pin_out = mem_func_out;
      pin_oe = '0;
    end else if (dec.pins_from_bsr) begin
      pin_out = bupd_ff[IN_PINS +: OUT_PINS];
      pin_oe = bupd_ff[IN_PINS + OUT_PINS +: OUT_PINS];
    end else begin
      pin_out = mem_func_out;
      pin_oe = mem_func_oe;
    end
  end

  assign tdo = tdo_ff;
  assign tdo_oe = tdo_oe_ff;
  assign active_ir = ir_ff;
endmodule : jid_decode

// *** verification/jid_decode_properties.sv ***
// Concurrent checks on the test-port instruction decoder's top-level ports
`timescale 1ns/10ps
module jid_decode_properties #(
  parameter int OUT_PINS = 8
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic tck,
  input wire logic trst_n,
  input wire logic tdo,
  input wire logic tdo_oe,
  input wire logic [OUT_PINS-1:0] mem_func_out,
  input wire logic [OUT_PINS-1:0] mem_func_oe,
  input wire logic [OUT_PINS-1:0] pin_out,
  input wire logic [OUT_PINS-1:0] pin_oe,
  input wire logic [7:0] active_ir
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);
  highz_oe_a: assert property (active_ir == jid_pkg::INS_HIGHZ |-> pin_oe == '0)
    else $error("output enabled under high-impedance code");
  func_pins_a: assert property (!(active_ir inside {8'h00, 8'h07, 8'h03})
    |-> pin_out == mem_func_out && pin_oe == mem_func_oe) else $error("pins not functional");
  ir_hold_a: assert property ($changed(active_ir) |=> $stable(active_ir) [*6])
    else $error("instruction changed twice within one test clock");
  tdo_fall_a: assert property ($changed(tdo) || $changed(tdo_oe)
    |-> !$past(tck) && !$past(tck, 2)) else $error("serial output moved with test clock high");
  rst_default_a: assert property ($rose(resetn) |-> active_ir == jid_pkg::INS_IDCODE)
    else $error("wrong instruction after reset");
  trst_default_a: assert property (!trst_n [*6] |-> active_ir == jid_pkg::INS_IDCODE)
    else $error("port reset did not restore the default instruction");
  clamp_hold_a: assert property (active_ir == 8'h07 && $past(active_ir) == 8'h07
    |-> $stable(pin_out) && $stable(pin_oe)) else $error("pins moved under clamp");
  extest_a: assert property (active_ir == 8'h00 && $stable(active_ir) && $changed(pin_out)
    |-> !$past(tck) && !$past(tck, 2)) else $error("pins moved outside an update");
  shift_len_a: assert property ($rose(tdo_oe) |-> tdo_oe [*6])
    else $error("shift window shorter than a test clock");
endmodule : jid_decode_properties

bind jid_decode jid_decode_properties #(.OUT_PINS(OUT_PINS)) u_props (
  .clk_sys(clk_sys), .resetn(resetn), .tck(tck), .trst_n(trst_n), .tdo(tdo), .tdo_oe(tdo_oe),
  .mem_func_out(mem_func_out), .mem_func_oe(mem_func_oe), .pin_out(pin_out), .pin_oe(pin_oe),
  .active_ir(active_ir));

// *** verification/jid_tap_ctl.sv ***
// Board-side test controller model driving the four-wire test port
`timescale 1ns/10ps
module jid_tap_ctl (
  output logic tck,
  output logic tms,
  output logic tdi,
  output logic trst_n,
  input wire logic tdo
);
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
    trst_n = 1'b1;
  end
  // One 80 ns test clock; tdo is read after the rise, well before the next fall moves it
  task automatic step(input logic m, input logic d, output logic q);
    tck = 1'b0;
    tms = m;
    tdi = d;
    #40;
    tck = 1'b1;
    #20;
    q = tdo;
    #20;
  endtask : step
  // Leading idle step also walks out of the reset state; the clock stands still between frames
  task automatic scan(input logic ir, input int n, input logic [63:0] din, output logic [63:0] dout);
    logic q;
    dout = '0;
    step(1'b0, 1'b0, q);
    repeat (ir ? 2 : 1) step(1'b1, 1'b0, q);
    repeat (2) step(1'b0, 1'b0, q);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], q);
      dout[i] = q;
    end
    step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
  endtask : scan
  // Clock held low so the port reset never races a test clock edge
  task automatic port_reset();
    tck = 1'b0;
    trst_n = 1'b0;
    #200;
    trst_n = 1'b1;
  endtask : port_reset
endmodule : jid_tap_ctl

// *** verification/test_jtag_instruction_decode.sv ***
// Self-checking bench for the test-port instruction decoder
`timescale 1ns/10ps
module test_jtag_instruction_decode;
  logic clk_sys, resetn, hold, tck, tms, tdi, trst_n, tdo, tdo_oe;
  logic [7:0] mem_in, f_out, f_oe, pin_out, pin_oe, active_ir, c;
  logic [15:0] pv;
  logic [63:0] din, dout, exp_q[$], act_q[$];
  int fail_count = 0;
  int samples_checked = 0;
  int seed = 76;
  jid_decode u_dut (
    .clk_sys(clk_sys), .resetn(resetn), .clk_en(1'b1), .tck(tck), .tms(tms), .tdi(tdi),
    .trst_n(trst_n), .tdo(tdo), .tdo_oe(tdo_oe), .mem_in_pins(mem_in), .mem_func_out(f_out),
    .mem_func_oe(f_oe), .pin_out(pin_out), .pin_oe(pin_oe), .active_ir(active_ir));
  jid_tap_ctl u_ctl (.tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n), .tdo(tdo));
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // Pin levels move every cycle unless a capture needs them steady
  always @(posedge clk_sys) begin
    #1;
    if (!hold) {mem_in, f_out, f_oe} = 24'($random(seed));
  end
  task automatic chk(input logic [63:0] e, input logic [63:0] a);
    exp_q.push_back(e);
    act_q.push_back(a);
  endtask : chk
  // Documented codes only, apart from the deliberate reserved-code scenario
  task automatic load(input logic [7:0] code);
    u_ctl.scan(1'b1, 8, {56'h0, code}, dout);
    chk(jid_pkg::IR_CAPTURE_VAL, dout[7:0]);
    chk(code, active_ir);
  endtask : load
  task automatic byp();
    din = {$random(seed), $random(seed)};
    u_ctl.scan(1'b0, 16, din, dout);
    chk({din[14:0], 1'b0}, dout[15:0]);
  endtask : byp
  task automatic pins(input logic func, input logic [15:0] e);
    @(negedge clk_sys);
    chk(func ? {f_oe, f_out} : e, {pin_oe, pin_out});
  endtask : pins
  task automatic complete_run();
    if (fail_count == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : complete_run
  initial begin
    forever begin
      wait (act_q.size() > 0);
      samples_checked++;
      if (act_q[0] !== exp_q[0]) begin
        fail_count++;
        $display("CHECK FAILED at %0t: expected %h, got %h", $time, exp_q[0], act_q[0]);
      end
      act_q.delete(0);
      exp_q.delete(0);
    end
  end
  initial begin
    #1_000_000;
    fail_count++;
    complete_run();
  end
  initial begin
    resetn = 1'b0;
    hold = 1'b0;
    {mem_in, f_out, f_oe} = '0;
    repeat (16) @(posedge clk_sys);
    #1 resetn = 1'b1;
    repeat (4) @(posedge clk_sys);
    chk(jid_pkg::INS_IDCODE, active_ir);
    din = {$random(seed), $random(seed)};
    u_ctl.scan(1'b0, 48, din, dout);
    chk({din[15:0], jid_pkg::ID_VALUE}, dout[47:0]);
    load(jid_pkg::INS_SAMPLE);
    hold = 1'b1;
    din = {$random(seed), $random(seed)};
    u_ctl.scan(1'b0, 40, din, dout);
    chk({din[15:0], f_oe, f_out, mem_in}, dout[39:0]);
    hold = 1'b0;
    pv = din[39:24];
    load(jid_pkg::INS_EXTEST);
    pins(1'b0, pv);
    hold = 1'b1;
    din = {$random(seed), $random(seed)};
    u_ctl.scan(1'b0, 24, din, dout);
    chk(mem_in, dout[7:0]);
    hold = 1'b0;
    pv = din[23:8];
    pins(1'b0, pv);
    load(jid_pkg::INS_CLAMP);
    byp();
    pins(1'b0, pv);
    load(jid_pkg::INS_HIGHZ);
    byp();
    @(negedge clk_sys);
    chk(8'h00, pin_oe);
    load(jid_pkg::INS_BYPASS);
    byp();
    pins(1'b1, '0);
    for (int k = 0; k < 3; k++) begin
      c = (k == 0) ? 8'h01 : (k == 1) ? 8'hFE : {4'h4, 4'($random(seed))};
      load(c);
      byp();
      pins(1'b1, '0);
    end
    u_ctl.port_reset();
    chk(jid_pkg::INS_IDCODE, active_ir);
    load(jid_pkg::INS_CLAMP);
    @(posedge clk_sys);
    #1 resetn = 1'b0;
    repeat (3) @(posedge clk_sys);
    #1 resetn = 1'b1;
    chk(jid_pkg::INS_IDCODE, active_ir);
    // The default instruction is back, so the identification register is the serial path
    din = {$random(seed), $random(seed)};
    u_ctl.scan(1'b0, 48, din, dout);
    chk({din[15:0], jid_pkg::ID_VALUE}, dout[47:0]);
    wait (act_q.size() == 0);
    complete_run();
  end
endmodule : test_jtag_instruction_decode
